// ==== bmdwr_pkg.sv ====
// Shared constants and carrier types for the board memory decode, wait and reset block
package bmdwr_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int CPU_CYCLE_NS = 250;
    // One processor cycle is a least time, so round up
    localparam int WAIT_CYCLES = (CPU_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POC_TIME_NS = 2000;
    localparam int POC_CYCLES = (POC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_CNT_W = $clog2(WAIT_CYCLES + 1);
    localparam int POC_CNT_W = $clog2(POC_CYCLES + 1);

    // ------------------------------------------------------------
    // Memory map
    // ------------------------------------------------------------
    localparam logic [15:0] ROM_BASE = 16'h0000;
    localparam logic [15:0] ROM_LAST = 16'h1fff;
    localparam logic [15:0] ROM_SOCKET_SIZE = 16'h0800;
    localparam int ROM_SOCKET_LSB = 11;
    localparam int ROM_SOCKETS = 4;
    localparam logic [15:0] RAM_BASE = 16'h2000;
    localparam logic [15:0] RAM_LAST = 16'h23ff;
    localparam int RAM_DEPTH = 1024;
    localparam int RAM_AW = 10;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;

    // ------------------------------------------------------------
    // Output ports and fields
    // ------------------------------------------------------------
    localparam logic [7:0] PORT_A_ADDR = 8'h0a;
    localparam logic [7:0] PORT_B_ADDR = 8'h0b;
    localparam logic [7:0] PORT_RESET_VAL = 8'h00;
    localparam int PORT_A_MEM_DIS_BIT = 7;

    // Processor cycle request, levels held for the machine cycle
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic mreq;
        logic iorq;
        logic rd;
        logic wr;
        logic fetch;
    } bmdwr_req_t;

    // What the board presents to the expansion bus
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic mem_rd;
        logic mem_wr;
    } bmdwr_bus_t;

endpackage

// ==== bmdwr_ram.sv ====
// On-board static RAM built from two nibble-wide arrays
module bmdwr_ram #(
    parameter int DEPTH = bmdwr_pkg::RAM_DEPTH,
    parameter int AW = bmdwr_pkg::RAM_AW
) (
    input wire logic i_ref_clk,
    input wire logic i_we,
    input wire logic [AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata
);
    import bmdwr_pkg::*;

    // ------------------------------------------------------------
    // Storage: upper and lower nibbles in separate arrays
    // ------------------------------------------------------------
    logic [3:0] hi_mem_ff [DEPTH];
    logic [3:0] lo_mem_ff [DEPTH];

    // Contents are random at power-up, so no reset here
    always_ff @(posedge i_ref_clk) begin
        if (i_we) begin
            hi_mem_ff[i_addr] <= i_wdata[7:4]; // RULE_12
            lo_mem_ff[i_addr] <= i_wdata[3:0]; // RULE_12
        end
    end

    // Read is asynchronous; the caller registers it
    assign o_rdata = {hi_mem_ff[i_addr], lo_mem_ff[i_addr]};
endmodule

// ==== bmdwr_ctrl.sv ====
// Board memory decode, wait-state insertion and reset distribution
// Function
// RULE_01: Processor cycle is 250 ns; one inserted wait lasts one such cycle.
// RULE_02: Bus ready low stretches the machine cycle by whole wait cycles, unlimited.
// RULE_03: Power-up gives a short low clear: processor reset, ports cleared, memory enabled.
// RULE_04: Processor reset disables interrupts, zeroes vector/refresh, mode zero, starts at zero.
// RULE_05: Bus reset low acts exactly like power-on clear on this board.
// RULE_06: Local reset low acts the same but never drives the bus reset.
// RULE_07: Four 2 KB ROM sockets at 0000-1FFF, RAM at 2000-23FF.
// RULE_08: One wait state on every memory cycle to 0000-1FFF.
// RULE_09: No automatic ROM wait when on-board memory is disabled.
// RULE_10: Fetch-only option limits that wait to opcode fetches; off by default.
// RULE_11: On-board RAM accesses get no inserted wait.
// RULE_12: Each RAM byte is split over two nibble-wide memories.
// RULE_13: Reads below 2400 come from board memory, others from the bus.
// RULE_14: Writes go to board and bus together; ROM contents never change.
// RULE_15: Slow bus memory pulls ready low itself to get its waits.
// RULE_16: Bank boards decode the port 40 byte; board ignores it.
// RULE_17: Board memory ignores bank select; only its own enable matters.
// RULE_18: With disable option, port 0A bit 7 high disables board memory.
// RULE_19: ROM wait is sampled at cycle start, one processor clock, released before next.
module bmdwr_ctrl #(
    parameter int WAIT_CLKS = bmdwr_pkg::WAIT_CYCLES,
    parameter int POC_CLKS = bmdwr_pkg::POC_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire bmdwr_pkg::bmdwr_req_t i_cpu_req,
    input wire logic i_bus_rdy,
    input wire logic i_bus_rst_n,
    input wire logic i_local_rst_n,
    input wire logic [7:0] i_bus_rdata,
    input wire logic [7:0] i_rom_rdata,
    input wire logic i_fetch_only_wait_option,
    input wire logic i_mem_disable_option,
    output logic o_cpu_wait,
    output logic o_cpu_reset_n,
    output logic o_poc_n,
    output logic [7:0] o_cpu_rdata,
    output bmdwr_pkg::bmdwr_bus_t o_bus,
    output logic [bmdwr_pkg::ROM_SOCKETS-1:0] o_rom_sel,
    output logic [7:0] o_port_a,
    output logic [7:0] o_port_b,
    output logic o_mem_enabled
);
    import bmdwr_pkg::*;

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic in_rom(input logic [15:0] addr);
        in_rom = (addr >= ROM_BASE) && (addr <= ROM_LAST); // RULE_07
    endfunction

    function automatic logic in_ram(input logic [15:0] addr);
        in_ram = (addr >= RAM_BASE) && (addr <= RAM_LAST); // RULE_07
    endfunction

    // ------------------------------------------------------------
    // Power-on clear and reset merge
    // ------------------------------------------------------------
    logic [POC_CNT_W-1:0] poc_cnt_ff, nxt_poc_cnt;
    logic poc_n_ff, nxt_poc_n;
    logic board_rst_ff, nxt_board_rst;

    // Clear pulse stretched after the supply reset so it is seen by all
    always_comb begin
        nxt_poc_cnt = poc_cnt_ff;
        nxt_poc_n = poc_n_ff;
        if (poc_cnt_ff != '0) begin
            nxt_poc_cnt = poc_cnt_ff - 1'b1;
        end else begin
            nxt_poc_n = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            poc_cnt_ff <= POC_CNT_W'(POC_CLKS); // RULE_03
            poc_n_ff <= 1'b0; // RULE_03
        end else begin
            poc_cnt_ff <= nxt_poc_cnt;
            poc_n_ff <= nxt_poc_n;
        end
    end

    // Bus and local resets are inputs only; nothing here drives the bus line
    always_comb begin
        nxt_board_rst = ~poc_n_ff | ~i_bus_rst_n | ~i_local_rst_n; // RULE_05 RULE_06
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            board_rst_ff <= 1'b1;
        end else begin
            board_rst_ff <= nxt_board_rst;
        end
    end

    // ------------------------------------------------------------
    // Output ports 0A and 0B, memory enable
    // ------------------------------------------------------------
    logic [7:0] port_a_ff, nxt_port_a;
    logic [7:0] port_b_ff, nxt_port_b;
    logic io_wr;
    logic mem_en;
    logic mem_en_ff, nxt_mem_en;

    assign io_wr = i_cpu_req.iorq & i_cpu_req.wr;

    // Bank-select writes to other ports are not decoded here
    always_comb begin
        nxt_port_a = port_a_ff;
        nxt_port_b = port_b_ff;
        if (io_wr && i_cpu_req.addr[7:0] == PORT_A_ADDR) begin
            nxt_port_a = i_cpu_req.wdata;
        end
        if (io_wr && i_cpu_req.addr[7:0] == PORT_B_ADDR) begin
            nxt_port_b = i_cpu_req.wdata;
        end
        // Enable depends only on the disable option and port A bit 7
        nxt_mem_en = ~(i_mem_disable_option & nxt_port_a[PORT_A_MEM_DIS_BIT]); // RULE_17 RULE_18
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst || board_rst_ff) begin
            port_a_ff <= PORT_RESET_VAL; // RULE_03 RULE_05
            port_b_ff <= PORT_RESET_VAL; // RULE_03 RULE_05
            mem_en_ff <= 1'b1; // RULE_03 RULE_05
        end else begin
            port_a_ff <= nxt_port_a;
            port_b_ff <= nxt_port_b;
            mem_en_ff <= nxt_mem_en;
        end
    end

    // Registered so decode and output agree; the option strap takes effect one clock late
    assign mem_en = mem_en_ff;

    // ------------------------------------------------------------
    // Wait-state machine
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ROM_WAIT,
        ST_BUSY
    } bmdwr_state_t;

    bmdwr_state_t state_ff, nxt_state;
    logic [WAIT_CNT_W-1:0] wait_cnt_ff, nxt_wait_cnt;
    logic wait_ff, nxt_wait;
    logic rom_wait_hit;

    // Sampled once at the start of the memory cycle
    assign rom_wait_hit = mem_en // RULE_09
        & in_rom(i_cpu_req.addr) // RULE_08
        & (~i_fetch_only_wait_option | i_cpu_req.fetch); // RULE_10

    always_comb begin
        nxt_state = state_ff;
        nxt_wait_cnt = wait_cnt_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (i_cpu_req.mreq) begin
                    if (rom_wait_hit) begin
                        nxt_state = ST_ROM_WAIT; // RULE_19
                        nxt_wait_cnt = WAIT_CNT_W'(WAIT_CLKS - 1); // RULE_01
                    end else begin
                        nxt_state = ST_BUSY; // RULE_11
                    end
                end
            end
            ST_ROM_WAIT: begin
                if (wait_cnt_ff == '0) begin
                    nxt_state = ST_BUSY; // RULE_19
                end else begin
                    nxt_wait_cnt = wait_cnt_ff - 1'b1;
                end
            end
            ST_BUSY: begin
                if (!i_cpu_req.mreq) begin
                    nxt_state = ST_IDLE;
                end
            end
        endcase
        // Bus ready can add any number of further waits
        nxt_wait = (nxt_state == ST_ROM_WAIT) | ~i_bus_rdy; // RULE_02 RULE_15
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst || board_rst_ff) begin
            state_ff <= ST_IDLE;
            wait_cnt_ff <= '0;
            wait_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            wait_cnt_ff <= nxt_wait_cnt;
            wait_ff <= nxt_wait;
        end
    end

    // ------------------------------------------------------------
    // On-board RAM
    // ------------------------------------------------------------
    logic ram_we;
    logic [7:0] ram_rdata;

    // ROM area writes reach only the bus
    assign ram_we = i_cpu_req.mreq & i_cpu_req.wr & mem_en & in_ram(i_cpu_req.addr); // RULE_14

    bmdwr_ram #(
        .DEPTH(RAM_DEPTH),
        .AW(RAM_AW)
    ) u_ram (
        .i_ref_clk(i_ref_clk),
        .i_we(ram_we),
        .i_addr(i_cpu_req.addr[RAM_AW-1:0]),
        .i_wdata(i_cpu_req.wdata),
        .o_rdata(ram_rdata)
    );

    // ------------------------------------------------------------
    // Read steering and bus drive
    // ------------------------------------------------------------
    logic [7:0] rdata_ff, nxt_rdata;
    bmdwr_bus_t bus_ff, nxt_bus;
    logic [ROM_SOCKETS-1:0] rom_sel_ff, nxt_rom_sel;
    logic board_owns;

    // Board answers its whole area while enabled, whatever the bus says
    assign board_owns = mem_en & (in_rom(i_cpu_req.addr) | in_ram(i_cpu_req.addr)); // RULE_13

    always_comb begin
        nxt_rdata = i_bus_rdata; // RULE_13
        nxt_rom_sel = '0;
        if (board_owns && in_rom(i_cpu_req.addr)) begin
            nxt_rdata = i_rom_rdata; // RULE_13
        end else if (board_owns) begin
            nxt_rdata = ram_rdata; // RULE_13
        end
        if (board_owns && in_rom(i_cpu_req.addr) && i_cpu_req.mreq) begin
            nxt_rom_sel[i_cpu_req.addr[ROM_SOCKET_LSB +: 2]] = 1'b1; // RULE_07
        end
        nxt_bus.addr = i_cpu_req.addr;
        nxt_bus.wdata = i_cpu_req.wdata;
        nxt_bus.mem_rd = i_cpu_req.mreq & i_cpu_req.rd & ~board_owns; // RULE_13
        nxt_bus.mem_wr = i_cpu_req.mreq & i_cpu_req.wr; // RULE_14
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst || board_rst_ff) begin
            rdata_ff <= 8'h00;
            bus_ff <= '0;
            rom_sel_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
            bus_ff <= nxt_bus;
            rom_sel_ff <= nxt_rom_sel;
        end
    end

    // ------------------------------------------------------------
    // Processor reset output
    // ------------------------------------------------------------
    logic cpu_reset_n_ff, nxt_cpu_reset_n;

    // Core clears interrupts, vector and refresh and starts at RESET_VECTOR
    always_comb begin
        nxt_cpu_reset_n = ~nxt_board_rst; // RULE_04
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            cpu_reset_n_ff <= 1'b0; // RULE_03
        end else begin
            cpu_reset_n_ff <= nxt_cpu_reset_n;
        end
    end

    // ------------------------------------------------------------
    // Outputs, each straight from a flip-flop
    // ------------------------------------------------------------
    assign o_cpu_wait = wait_ff;
    assign o_cpu_reset_n = cpu_reset_n_ff;
    assign o_poc_n = poc_n_ff;
    assign o_cpu_rdata = rdata_ff;
    assign o_bus = bus_ff;
    assign o_rom_sel = rom_sel_ff;
    assign o_port_a = port_a_ff;
    assign o_port_b = port_b_ff;
    assign o_mem_enabled = mem_en_ff;
endmodule

// ==== bmdwr_ctrl_chk.sv ====
// Assertion checker for the memory decode, wait and reset block
module bmdwr_ctrl_chk #(
    parameter int WAIT_CLKS = bmdwr_pkg::WAIT_CYCLES,
    parameter int POC_CLKS = bmdwr_pkg::POC_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_srst,
    input wire bmdwr_pkg::bmdwr_req_t i_cpu_req,
    input wire logic i_bus_rdy,
    input wire logic i_bus_rst_n,
    input wire logic i_local_rst_n,
    input wire logic [7:0] i_bus_rdata,
    input wire logic i_fetch_only_wait_option,
    input wire logic i_mem_disable_option,
    input wire logic o_cpu_wait,
    input wire logic o_cpu_reset_n,
    input wire logic o_poc_n,
    input wire logic [7:0] o_cpu_rdata,
    input wire bmdwr_pkg::bmdwr_bus_t o_bus,
    input wire logic [bmdwr_pkg::ROM_SOCKETS-1:0] o_rom_sel,
    input wire logic [7:0] o_port_a,
    input wire logic [7:0] o_port_b,
    input wire logic o_mem_enabled
);
    import bmdwr_pkg::*;
    logic [15:0] wait_run_ff, nxt_wait_run, poc_run_ff, nxt_poc_run;
    // Run lengths of wait and clear pulses, too long for a repetition
    always_comb begin
        nxt_wait_run = o_cpu_wait ? wait_run_ff + 16'h0001 : 16'h0000;
        nxt_poc_run = o_poc_n ? 16'h0000 : poc_run_ff + 16'h0001;
    end
    always_ff @(posedge i_ref_clk) begin
        wait_run_ff <= i_srst ? 16'h0000 : nxt_wait_run;
        poc_run_ff <= i_srst ? 16'h0000 : nxt_poc_run;
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_srst);
    // Start of a memory cycle that lands in the enabled ROM area
    sequence s_rom_go;
        $rose(i_cpu_req.mreq) && i_cpu_req.addr <= ROM_LAST && o_mem_enabled && o_cpu_reset_n
            && (!i_fetch_only_wait_option || i_cpu_req.fetch);
    endsequence
    sequence s_reset_in;
        (!i_bus_rst_n || !i_local_rst_n) [*2];
    endsequence
    chk_rom_wait_on: assert property (s_rom_go |=> o_cpu_wait [*8])
        else $error("rom wait missing or short");
    chk_wait_release: assert property (o_cpu_wait && wait_run_ff >= WAIT_CLKS - 1 && i_bus_rdy |=> !o_cpu_wait)
        else $error("wait held past one processor cycle");
    chk_ram_no_wait: assert property ($rose(i_cpu_req.mreq) && i_cpu_req.addr inside {[RAM_BASE:RAM_LAST]}
        && i_bus_rdy |=> !o_cpu_wait) else $error("ram access waited");
    chk_fetch_skip: assert property ($rose(i_cpu_req.mreq) && i_cpu_req.addr <= ROM_LAST && i_fetch_only_wait_option
        && !i_cpu_req.fetch && i_bus_rdy |=> !o_cpu_wait) else $error("non-fetch waited");
    chk_off_no_wait: assert property ($rose(i_cpu_req.mreq) && i_cpu_req.addr <= ROM_LAST && !o_mem_enabled
        && i_bus_rdy |=> !o_cpu_wait) else $error("disabled rom waited");
    chk_rdy_stretch: assert property (i_cpu_req.mreq && !i_bus_rdy && o_cpu_reset_n |=> o_cpu_wait)
        else $error("ready low ignored");
    chk_bus_read: assert property (i_cpu_req.mreq && i_cpu_req.rd && (i_cpu_req.addr > RAM_LAST || !o_mem_enabled)
        |=> o_bus.mem_rd && o_cpu_rdata == $past(i_bus_rdata)) else $error("bus read not steered");
    chk_board_read: assert property (i_cpu_req.mreq && i_cpu_req.rd && i_cpu_req.addr <= RAM_LAST && o_mem_enabled
        |=> !o_bus.mem_rd) else $error("board read leaked to bus");
    chk_write_both: assert property (i_cpu_req.mreq && i_cpu_req.wr |=> o_bus.mem_wr
        && o_bus.addr == $past(i_cpu_req.addr) && o_bus.wdata == $past(i_cpu_req.wdata)) else $error("write not on bus");
    chk_rom_socket: assert property (i_cpu_req.mreq && i_cpu_req.addr <= ROM_LAST && o_mem_enabled
        |=> o_rom_sel == 4'h1 << $past(i_cpu_req.addr[12:11])) else $error("wrong rom socket");
    chk_reset_clear: assert property (s_reset_in |=> o_port_a == 8'h00 && o_port_b == 8'h00
        && !o_cpu_reset_n && o_mem_enabled) else $error("reset did not clear board");
    chk_poc_start: assert property ($fell(i_srst) |-> !o_poc_n && !o_cpu_reset_n)
        else $error("no clear pulse after power up");
    chk_poc_short: assert property (poc_run_ff <= POC_CLKS + 4)
        else $error("clear pulse too long");
    chk_mem_enable: assert property (o_mem_enabled == !($past(i_mem_disable_option) && o_port_a[PORT_A_MEM_DIS_BIT]))
        else $error("memory enable wrong");
endmodule
bind bmdwr_ctrl bmdwr_ctrl_chk #(.WAIT_CLKS(WAIT_CLKS), .POC_CLKS(POC_CLKS)) u_bmdwr_ctrl_chk (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_cpu_req(i_cpu_req), .i_bus_rdy(i_bus_rdy),
    .i_bus_rst_n(i_bus_rst_n), .i_local_rst_n(i_local_rst_n), .i_bus_rdata(i_bus_rdata),
    .i_fetch_only_wait_option(i_fetch_only_wait_option), .i_mem_disable_option(i_mem_disable_option),
    .o_cpu_wait(o_cpu_wait), .o_cpu_reset_n(o_cpu_reset_n), .o_poc_n(o_poc_n), .o_cpu_rdata(o_cpu_rdata),
    .o_bus(o_bus), .o_rom_sel(o_rom_sel), .o_port_a(o_port_a), .o_port_b(o_port_b), .o_mem_enabled(o_mem_enabled));

// ==== bmdwr_bus_mem.sv ====
// Expansion bus memory board model with optional ready stalls
module bmdwr_bus_mem (
    input wire logic i_ref_clk,
    input wire bmdwr_pkg::bmdwr_bus_t i_bus,
    input wire logic [3:0] i_stall,
    output logic [7:0] o_rdata,
    output logic o_rdy
);
    timeunit 1ns;
    timeprecision 1ps;
    import bmdwr_pkg::*;
    logic [7:0] mem [64];
    logic [3:0] stall_cnt = 4'h0;
    logic [7:0] last_rd = 8'h00;
    logic prev_acc = 1'b0;
    // Known fill so unwritten bytes still compare
    initial for (int i = 0; i < 64; i++) mem[i] = 8'(i) ^ 8'hc3;
    // Slow board asks for its own waits at each new access
    always @(posedge i_ref_clk) begin
        prev_acc <= i_bus.mem_rd | i_bus.mem_wr;
        if ((i_bus.mem_rd | i_bus.mem_wr) && !prev_acc) stall_cnt <= i_stall;
        else if (stall_cnt != 4'h0) stall_cnt <= stall_cnt - 4'h1;
        if (i_bus.mem_wr) mem[i_bus.addr[5:0]] <= i_bus.wdata;
        if (i_bus.mem_rd) last_rd <= mem[i_bus.addr[5:0]];
    end
    assign o_rdy = (stall_cnt == 4'h0); // Pulled up when nobody stalls
    // Released data lines show the inverse byte, never a stale copy
    assign o_rdata = i_bus.mem_rd ? mem[i_bus.addr[5:0]] : ~last_rd;
endmodule

// ==== bmdwr_ctrl_tb.sv ====
// Self-checking testbench for the memory decode, wait and reset block
module bmdwr_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bmdwr_pkg::*;
    logic clk = 1'b0, srst = 1'b1, rdy, bus_rst_n = 1'b1, local_rst_n = 1'b1, fo_opt = 1'b0, md_opt = 1'b0;
    logic cpu_wait, cpu_reset_n, poc_n, mem_en;
    logic [7:0] bus_rdata, rom_rdata = 8'h00, cpu_rdata, port_a, port_b;
    logic [3:0] stall = 4'h0, rom_sel;
    bmdwr_req_t req = '0;
    bmdwr_bus_t bus;
    int error_cnt = 0, tests_run = 0;
    always #10 clk = ~clk;
    bmdwr_ctrl u_bmdwr_ctrl (.i_ref_clk(clk), .i_srst(srst), .i_cpu_req(req), .i_bus_rdy(rdy),
        .i_bus_rst_n(bus_rst_n), .i_local_rst_n(local_rst_n), .i_bus_rdata(bus_rdata), .i_rom_rdata(rom_rdata),
        .i_fetch_only_wait_option(fo_opt), .i_mem_disable_option(md_opt), .o_cpu_wait(cpu_wait),
        .o_cpu_reset_n(cpu_reset_n), .o_poc_n(poc_n), .o_cpu_rdata(cpu_rdata), .o_bus(bus),
        .o_rom_sel(rom_sel), .o_port_a(port_a), .o_port_b(port_b), .o_mem_enabled(mem_en));
    bmdwr_bus_mem u_bmdwr_bus_mem (.i_ref_clk(clk), .i_bus(bus), .i_stall(stall), .o_rdata(bus_rdata), .o_rdy(rdy));
    task check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task end_sim;
        $display("mismatches %0d of %0d compares", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // One memory cycle; mreq held until the wait ends, then one idle clock
    task cyc(input logic [15:0] a, input logic rd, input logic fe, input logic [7:0] wd,
             output int wc, output logic [7:0] rv, output logic [3:0] sl);
        int k;
        @(negedge clk);
        req = '{addr: a, wdata: wd, mreq: 1'b1, rd: rd, wr: !rd, fetch: fe, default: 1'b0};
        wc = 0;
        k = 0;
        @(negedge clk);
        sl = rom_sel;
        while ((k < 4 || cpu_wait === 1'b1) && k < 60) begin
            if (cpu_wait === 1'b1) wc++;
            k++;
            @(negedge clk);
        end
        rv = cpu_rdata;
        req = '0;
    endtask
    task io_write(input logic [7:0] p, input logic [7:0] d);
        @(negedge clk);
        req = '{addr: {8'h00, p}, wdata: d, iorq: 1'b1, wr: 1'b1, default: 1'b0};
        @(negedge clk);
        req = '0;
    endtask
    // Bounded wait for the processor to leave reset
    task wait_cpu(output int n);
        n = 0;
        while (cpu_reset_n !== 1'b1 && n < 400) begin
            n++;
            @(negedge clk);
        end
    endtask
    task t_reset_poc;
        int n;
        srst = 1'b1;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
        check({poc_n, cpu_reset_n, mem_en}, 3'b001);
        check({port_a, port_b}, {PORT_RESET_VAL, PORT_RESET_VAL});
        wait_cpu(n);
        check(16'(n >= POC_CYCLES && n < 400), 16'h0001);
    endtask
    task t_rom_sockets;
        int wc;
        logic [7:0] rv;
        logic [3:0] sl;
        for (int s = 0; s < ROM_SOCKETS; s++) begin
            rom_rdata = 8'h50 + 8'(s);
            cyc(ROM_BASE + 16'(s) * ROM_SOCKET_SIZE + (s == 3 ? 16'h07ff : 16'h0005), 1'b1, 1'b0, 8'h00, wc, rv, sl);
            check(16'(wc), 16'(WAIT_CYCLES));
            check(rv, 8'h50 + 8'(s));
            check(sl, 4'h1 << s);
        end
        cyc(16'h0010, 1'b0, 1'b0, 8'h77, wc, rv, sl);
        check(u_bmdwr_bus_mem.mem[16], 8'h77);
    endtask
    task t_ram_and_bus;
        int wc;
        logic [7:0] rv;
        logic [3:0] sl;
        cyc(16'h2005, 1'b0, 1'b0, 8'ha5, wc, rv, sl);
        check(16'(wc), 16'h0000);
        cyc(16'h23ff, 1'b0, 1'b0, 8'h3c, wc, rv, sl);
        cyc(16'h2405, 1'b0, 1'b0, 8'h96, wc, rv, sl);
        check(u_bmdwr_bus_mem.mem[5], 8'h96);
        cyc(16'h2005, 1'b1, 1'b0, 8'h00, wc, rv, sl);
        check(rv, 8'ha5);
        cyc(16'h23ff, 1'b1, 1'b0, 8'h00, wc, rv, sl);
        check(rv, 8'h3c);
        cyc(16'h2405, 1'b1, 1'b0, 8'h00, wc, rv, sl);
        check(rv, 8'h96);
        fo_opt = 1'b1;
        cyc(16'h0100, 1'b1, 1'b0, 8'h00, wc, rv, sl);
        check(16'(wc), 16'h0000);
        cyc(16'h0100, 1'b1, 1'b1, 8'h00, wc, rv, sl);
        check(16'(wc), 16'(WAIT_CYCLES));
        fo_opt = 1'b0;
        stall = 4'h3;
        cyc(16'h3007, 1'b1, 1'b0, 8'h00, wc, rv, sl);
        check(16'(wc), 16'h0003);
        check(rv, 8'h07 ^ 8'hc3);
        stall = 4'h0;
    endtask
    task t_disable_and_resets;
        int wc;
        logic [7:0] rv;
        logic [3:0] sl;
        md_opt = 1'b1;
        io_write(8'h40, 8'h00);
        check(mem_en, 1'b1);
        io_write(PORT_B_ADDR, 8'h33);
        io_write(PORT_A_ADDR, 8'h80);
        check({mem_en, port_a}, {1'b0, 8'h80});
        cyc(16'h0100, 1'b1, 1'b0, 8'h00, wc, rv, sl);
        check(16'(wc), 16'h0000);
        check(rv, 8'hc3);
        for (int r = 0; r < 2; r++) begin
            io_write(PORT_A_ADDR, 8'h80);
            io_write(PORT_B_ADDR, 8'h33);
            bus_rst_n = (r != 0);
            local_rst_n = (r == 0);
            repeat (3) @(negedge clk);
            check({port_a, port_b}, {PORT_RESET_VAL, PORT_RESET_VAL});
            check(16'({cpu_reset_n, mem_en}), 16'h0001);
            bus_rst_n = 1'b1;
            local_rst_n = 1'b1;
            wait_cpu(wc);
        end
        md_opt = 1'b0;
    endtask
    // Watchdog: the whole sequence needs a few hundred clocks
    initial begin
        #400000;
        error_cnt++;
        end_sim();
    end
    initial begin
        t_reset_poc();
        t_rom_sockets();
        t_ram_and_bus();
        t_disable_and_resets();
        t_reset_poc();
        end_sim();
    end
endmodule
